// >>> design/usm_status_mode.sv
// usm_status_mode: line/modem status and enhanced mode logic of one channel, AXI4-Lite slave
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module usm_status_mode #(
  parameter int LVL_W = 7
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire usm_pkg::usm_rx_char_t rx_char,
  input  wire usm_pkg::usm_rx_head_t rx_head,
  input  wire usm_pkg::usm_tx_t      tx_stat,
  input  wire logic [LVL_W-1:0]      rx_level,
  input  wire logic [LVL_W-1:0]      tx_level,
  input  wire usm_pkg::usm_modem_t   modem_pins_n,
  output logic                       rx_fifo_wr,
  output logic                       tx_stop,
  output logic                       rts_n,
  output logic                       dtr_n,
  output logic [5:0]                 hyst_chars,
  output logic                       sample_16x,
  output logic                       line_irq,
  output logic                       modem_irq
);
  if (LVL_W < 1 || LVL_W > 8) begin : g_bad_lvl
    $error("usm_status_mode: LVL_W must be 1 to 8");
  end

  //////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic [3:0] reg_hit(input logic [7:0] a);
    reg_hit = {a == usm_pkg::OFS_CTRL, a == usm_pkg::OFS_SCRATCH,
               a == usm_pkg::OFS_MODEM, a == usm_pkg::OFS_LINE};
  endfunction

  function automatic logic [5:0] hyst_of(input logic [3:0] code);
    case (code)
      4'h0: hyst_of = 6'd0;
      4'h1: hyst_of = 6'd4;
      4'h2: hyst_of = 6'd6;
      4'h3: hyst_of = 6'd8;
      4'h4: hyst_of = 6'd8;
      4'h5: hyst_of = 6'd16;
      4'h6: hyst_of = 6'd24;
      4'h7: hyst_of = 6'd32;
      4'h8: hyst_of = 6'd40;
      4'h9: hyst_of = 6'd44;
      4'ha: hyst_of = 6'd48;
      4'hb: hyst_of = 6'd52;
      4'hc: hyst_of = 6'd12;
      4'hd: hyst_of = 6'd20;
      4'he: hyst_of = 6'd28;
      default: hyst_of = 6'd36;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes
  logic        aw_rdy_ff, w_rdy_ff, ar_rdy_ff, bvalid_ff, rvalid_ff;
  logic        aw_hold_ff, w_hold_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;

  wire aw_hs  = s_axi_awvalid & aw_rdy_ff;
  wire w_hs   = s_axi_wvalid & w_rdy_ff;
  wire ar_hs  = s_axi_arvalid & ar_rdy_ff;
  wire do_wr  = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire nxt_aw_hold = (aw_hold_ff & ~do_wr) | aw_hs;
  wire nxt_w_hold  = (w_hold_ff & ~do_wr) | w_hs;
  wire nxt_bvalid  = do_wr | (bvalid_ff & ~s_axi_bready);
  wire nxt_rvalid  = ar_hs | (rvalid_ff & ~s_axi_rready);

  wire [3:0] wr_hit = reg_hit(awaddr_ff);
  wire [3:0] rd_hit = reg_hit(s_axi_araddr);

  //////////////////////////////////////////////////////////////////////////////
  // register state
  logic [12:0]      ctrl_ff;
  logic [7:0]       scratch_ff, mode_sel_ff;
  logic [3:0]       rx_err_ff;    // overrun, parity, framing, break
  logic [3:0]       delta_ff;     // cd, ri, dsr, cts
  logic [3:0]       msr_prev_ff;
  logic [3:0]       pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_filt_ff;
  logic [LVL_W-1:0] err_cnt_ff;
  logic             brk_hold_ff, txh_empty_ff, alt_tx_ff, line_pend_ff;
  logic             rx_fifo_wr_ff, tx_stop_ff, rts_n_ff, dtr_n_ff;
  logic [5:0]       hyst_ff;
  logic             sample_16x_ff, line_irq_ff, modem_irq_ff;

  wire fifo_mode = ctrl_ff[usm_pkg::C_FIFO];
  wire swap      = ctrl_ff[usm_pkg::C_SWAP];
  wire loop_on   = ctrl_ff[usm_pkg::C_LOOP];

  wire wr_ctrl    = do_wr & wr_hit[3];
  wire wr_scratch = do_wr & wr_hit[2] & wstrb_ff[0] & ~swap;
  wire wr_mode    = do_wr & wr_hit[2] & wstrb_ff[0] & swap;
  wire rd_line    = ar_hs & rd_hit[0];
  wire rd_modem   = ar_hs & rd_hit[1];
  wire rd_level   = ar_hs & rd_hit[2] & swap;

  //////////////////////////////////////////////////////////////////////////////
  // receive status
  wire rx_err_in  = rx_char.perr | rx_char.ferr | rx_char.brk;
  wire head_err   = rx_head.perr | rx_head.ferr | rx_head.brk;
  wire ovr_set    = rx_char.char_done & rx_char.fifo_full;
  // a break lasting many frames would flood the FIFO; only its first frame goes in
  wire brk_dup    = fifo_mode & rx_char.brk & brk_hold_ff;
  wire rx_push    = rx_char.char_done & ~rx_char.fifo_full & ~brk_dup;
  wire err_inc    = rx_push & rx_err_in;
  wire err_dec    = rx_head.head_pop & head_err;
  wire [3:0] err_set = {ovr_set,
                        rx_head.head_new & rx_head.perr,
                        rx_head.head_new & rx_head.ferr,
                        rx_head.head_new & rx_head.brk};
  wire [3:0] nxt_rx_err = err_set | (rx_err_ff & ~{4{rd_line}});
  // immediate mode signals on FIFO entry, delayed mode when the char is on top
  wire line_trig  = ovr_set | (mode_sel_ff[usm_pkg::M_LSIM] ? err_inc
                                                             : rx_head.head_new & head_err);
  wire nxt_line_pend = line_trig | (line_pend_ff & ~rd_line);
  wire [LVL_W-1:0] nxt_err_cnt = err_cnt_ff + LVL_W'(err_inc) - LVL_W'(err_dec);

  //////////////////////////////////////////////////////////////////////////////
  // transmit status
  wire txh_empty = fifo_mode ? (tx_level == '0) : txh_empty_ff;
  wire tx_idle   = txh_empty & ~tx_stat.shift_busy;

  wire [7:0] line_status = {err_cnt_ff != '0,
                            tx_idle, txh_empty,
                            rx_err_ff[0], rx_err_ff[1], rx_err_ff[2], rx_err_ff[3],
                            rx_level != '0};

  //////////////////////////////////////////////////////////////////////////////
  // modem inputs
  wire [3:0] loop_bits = {ctrl_ff[usm_pkg::C_OUT2], ctrl_ff[usm_pkg::C_OUT1],
                          ctrl_ff[usm_pkg::C_DTR], ctrl_ff[usm_pkg::C_RTS]};
  wire [3:0] msr_lvl   = loop_on ? loop_bits : ~pin_filt_ff;
  wire [3:0] chg       = msr_lvl ^ msr_prev_ff;
  // status ri falling means the pin rose: the end of ringing
  wire [3:0] delta_set = {chg[3], msr_prev_ff[2] & ~msr_lvl[2], chg[1], chg[0]};
  wire [3:0] nxt_delta = delta_set | (delta_ff & ~{4{rd_modem}});
  wire [7:0] modem_status = {msr_lvl, delta_ff};

  //////////////////////////////////////////////////////////////////////////////
  // level counter and read mux
  wire [1:0] cnt_mode = mode_sel_ff[1:0];
  wire lvl_tx = (cnt_mode == usm_pkg::CNT_TX) | ((cnt_mode == usm_pkg::CNT_ALT) & alt_tx_ff);
  wire [7:0] level_val = lvl_tx ? 8'(tx_level) : 8'(rx_level);
  wire [7:0] scr_val   = swap ? level_val : scratch_ff;
  wire [31:0] rd_val   = rd_hit[0] ? {24'h00_0000, line_status} :
                         rd_hit[1] ? {24'h00_0000, modem_status} :
                         rd_hit[2] ? {24'h00_0000, scr_val} :
                         rd_hit[3] ? {19'h0_0000, ctrl_ff} : 32'h0000_0000;
  wire nxt_alt_tx = wr_mode ? 1'b0 :
                    (rd_level & cnt_mode == usm_pkg::CNT_ALT) ? ~alt_tx_ff : alt_tx_ff;
  wire [12:0] nxt_ctrl = {wstrb_ff[1] ? wdata_ff[12:8] : ctrl_ff[12:8],
                          wstrb_ff[0] ? wdata_ff[7:0] : ctrl_ff[7:0]};
  wire nxt_dir = tx_idle ^ mode_sel_ff[usm_pkg::M_POL];

  //////////////////////////////////////////////////////////////////////////////
  // bus flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_rdy_ff  <= 1'b1;
      w_rdy_ff   <= 1'b1;
      ar_rdy_ff  <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      rvalid_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bresp_ff   <= usm_pkg::RESP_OKAY;
      rresp_ff   <= usm_pkg::RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      aw_rdy_ff  <= ~nxt_aw_hold;
      w_rdy_ff   <= ~nxt_w_hold;
      bvalid_ff  <= nxt_bvalid;
      rvalid_ff  <= nxt_rvalid;
      ar_rdy_ff  <= ~nxt_rvalid;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        bresp_ff <= (|wr_hit) ? usm_pkg::RESP_OKAY : usm_pkg::RESP_SLVERR;
      end
      if (ar_hs) begin
        rdata_ff <= rd_val;
        rresp_ff <= (|rd_hit) ? usm_pkg::RESP_OKAY : usm_pkg::RESP_SLVERR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_ff     <= usm_pkg::CTRL_RST;
      scratch_ff  <= usm_pkg::SCRATCH_RST;
      mode_sel_ff <= usm_pkg::MODE_SEL_RST;
      alt_tx_ff   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_scratch) begin
        scratch_ff <= wdata_ff[7:0];
      end
      if (wr_mode) begin
        mode_sel_ff <= wdata_ff[7:0];
      end
      alt_tx_ff <= nxt_alt_tx;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status and modem tracking
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_err_ff    <= 4'h0;
      err_cnt_ff   <= '0;
      brk_hold_ff  <= 1'b0;
      line_pend_ff <= 1'b0;
      txh_empty_ff <= 1'b1;
      delta_ff     <= 4'h0;
      msr_prev_ff  <= 4'h0;
      pin_s1_ff    <= usm_pkg::MODEM_PIN_RST;
      pin_s2_ff    <= usm_pkg::MODEM_PIN_RST;
      pin_s3_ff    <= usm_pkg::MODEM_PIN_RST;
      pin_filt_ff  <= usm_pkg::MODEM_PIN_RST;
    end else begin
      rx_err_ff    <= nxt_rx_err;
      err_cnt_ff   <= nxt_err_cnt;
      line_pend_ff <= nxt_line_pend;
      if (rx_char.char_done) begin
        brk_hold_ff <= rx_char.brk;
      end
      // the transfer to the shifter wins over a same-cycle host load
      txh_empty_ff <= tx_stat.xfer | (txh_empty_ff & ~tx_stat.load);
      delta_ff     <= nxt_delta;
      msr_prev_ff  <= msr_lvl;
      pin_s1_ff    <= modem_pins_n;
      pin_s2_ff    <= pin_s1_ff;
      pin_s3_ff    <= pin_s2_ff;
      for (int i = 0; i < 4; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_filt_ff[i] <= pin_s3_ff[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_fifo_wr_ff <= 1'b0;
      tx_stop_ff    <= 1'b0;
      rts_n_ff      <= 1'b1;
      dtr_n_ff      <= 1'b1;
      hyst_ff       <= 6'd0;
      sample_16x_ff <= 1'b1;
      line_irq_ff   <= 1'b0;
      modem_irq_ff  <= 1'b0;
    end else begin
      rx_fifo_wr_ff <= rx_push;
      // only re-evaluated between characters so a stop never cuts one short
      if (!tx_stat.shift_busy) begin
        tx_stop_ff <= ctrl_ff[usm_pkg::C_ACTS] & ~msr_lvl[0];
      end
      rts_n_ff      <= ctrl_ff[usm_pkg::C_ADIR] ? nxt_dir : ~ctrl_ff[usm_pkg::C_RTS];
      dtr_n_ff      <= ~ctrl_ff[usm_pkg::C_DTR];
      hyst_ff       <= hyst_of({mode_sel_ff[usm_pkg::M_XHYS +: 2], ctrl_ff[usm_pkg::C_HYS +: 2]});
      sample_16x_ff <= mode_sel_ff[usm_pkg::M_S16];
      line_irq_ff   <= nxt_line_pend & ctrl_ff[usm_pkg::C_IELS];
      modem_irq_ff  <= (|nxt_delta) & ctrl_ff[usm_pkg::C_IEMS];
    end
  end

  assign s_axi_awready = aw_rdy_ff;
  assign s_axi_wready  = w_rdy_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ar_rdy_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign rx_fifo_wr    = rx_fifo_wr_ff;
  assign tx_stop       = tx_stop_ff;
  assign rts_n         = rts_n_ff;
  assign dtr_n         = dtr_n_ff;
  assign hyst_chars    = hyst_ff;
  assign sample_16x    = sample_16x_ff;
  assign line_irq      = line_irq_ff;
  assign modem_irq     = modem_irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_full_char;
    rx_char.char_done && rx_char.fifo_full;
  endsequence
  sequence s_line_read;
    ar_hs && rd_hit[0];
  endsequence
  sequence s_modem_read;
    ar_hs && rd_hit[1];
  endsequence

  a_overrun_flag: assert property (s_full_char |=> rx_err_ff[3] && !rx_fifo_wr)
    else $error("overrun not flagged or char written");
  a_parity_hold: assert property (rx_head.head_new && rx_head.perr && !rd_line ##1 s_line_read
                                   |=> s_axi_rdata[2])
    else $error("parity flag missing on read");
  a_framing_flag: assert property (rx_head.head_new && rx_head.ferr |=> rx_err_ff[1])
    else $error("framing flag not set");
  a_break_once: assert property (fifo_mode && rx_char.char_done && rx_char.brk
                                  ##1 rx_char.char_done && rx_char.brk && fifo_mode |=> !rx_fifo_wr)
    else $error("second break char entered fifo");
  a_txe_fifo: assert property ((s_line_read and (fifo_mode && tx_level != '0)) |=> !s_axi_rdata[5])
    else $error("holding empty while fifo holds data");
  a_idle_busy: assert property ((s_line_read and tx_stat.shift_busy) |=> !s_axi_rdata[6])
    else $error("idle reported while shifting");
  a_delta_cts: assert property ($changed(msr_lvl[0]) |=> delta_ff[0])
    else $error("cts delta missed");
  a_ring_edge: assert property ($rose(msr_lvl[2]) && !delta_ff[2] && !rd_modem |=> !delta_ff[2])
    else $error("ring delta on leading edge");
  a_cts_stop: assert property (tx_stat.shift_busy |=> $stable(tx_stop))
    else $error("tx stop changed mid character");
  a_loop_cts: assert property ((s_modem_read and loop_on) |=> s_axi_rdata[4] == $past(ctrl_ff[usm_pkg::C_RTS]))
    else $error("loopback cts not rts bit");
  a_loop_dsr: assert property ((s_modem_read and loop_on) |=> s_axi_rdata[5] == $past(ctrl_ff[usm_pkg::C_DTR]))
    else $error("loopback dsr not dtr bit");
  a_swap_write: assert property (wr_hit[2] && do_wr && swap |=> $stable(scratch_ff))
    else $error("scratch written under swap");
  a_alt_restart: assert property (wr_mode |=> !alt_tx_ff)
    else $error("alternation not restarted");
  a_dir_level: assert property (ctrl_ff[usm_pkg::C_ADIR] && !tx_idle && !mode_sel_ff[usm_pkg::M_POL]
                                 |=> !rts_n)
    else $error("direction not low while sending");
endmodule
`default_nettype wire

// >>> inc/usm_pkg.sv
// usm_pkg: register map, field positions, reset values and carrier types
// Function
// - full FIFO: flag overrun, drop new char
// - parity flag for char at holding location
// - framing flag for char at holding location
// - break flagged; FIFO takes one break char
// - holding-empty set on transfer, FIFO empty
// - transmitter empty when holding and shifter empty
// - FIFO error flag while error bytes remain
// - delta on CTS/DSR/CD change, modem interrupt
// - ring delta only at ringing end
// - auto CTS stops after current character
// - CTS status inverted pin, loopback RTS bit
// - DSR/RI/CD inverted pins, loopback control bits
// - eight-bit scratch byte, resets to ones
// - swap routes scratch writes to mode register
// - two-bit field selects level counter source
// - alternating mode: receive, transmit, repeat
// - direction low transmitting, polarity inverts
// - four-bit code selects hysteresis characters
// - line interrupt at holding or FIFO entry
// - sampling 8x or 16x, 16x default
// - data ready while characters wait
// - loopback bit substitutes control for inputs
package usm_pkg;
  localparam logic [7:0]  OFS_LINE      = 8'h00;
  localparam logic [7:0]  OFS_MODEM     = 8'h04;
  localparam logic [7:0]  OFS_SCRATCH   = 8'h08;
  localparam logic [7:0]  OFS_CTRL      = 8'h0c;
  localparam logic [7:0]  SCRATCH_RST   = 8'hff;
  localparam logic [7:0]  MODE_SEL_RST  = 8'h80;
  localparam logic [12:0] CTRL_RST      = 13'h0000;
  localparam logic [3:0]  MODEM_PIN_RST = 4'hf;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // control register fields
  localparam int C_DTR  = 0;
  localparam int C_RTS  = 1;
  localparam int C_OUT1 = 2;
  localparam int C_OUT2 = 3;
  localparam int C_LOOP = 4;
  localparam int C_FIFO = 5;
  localparam int C_HYS  = 6;
  localparam int C_SWAP = 8;
  localparam int C_ACTS = 9;
  localparam int C_ADIR = 10;
  localparam int C_IELS = 11;
  localparam int C_IEMS = 12;
  // enhanced mode select fields
  localparam int M_POL  = 3;
  localparam int M_XHYS = 4;
  localparam int M_LSIM = 6;
  localparam int M_S16  = 7;
  localparam logic [1:0] CNT_TX  = 2'h1;
  localparam logic [1:0] CNT_ALT = 2'h3;
  // line status fields
  localparam int LS_DR   = 0;
  localparam int LS_OE   = 1;
  localparam int LS_TXE  = 5;
  localparam int LS_IDLE = 6;
  localparam int LS_FERR = 7;

  typedef struct packed {
    logic char_done;
    logic perr;
    logic ferr;
    logic brk;
    logic fifo_full;
  } usm_rx_char_t;

  typedef struct packed {
    logic head_new;
    logic head_pop;
    logic perr;
    logic ferr;
    logic brk;
  } usm_rx_head_t;

  typedef struct packed {
    logic load;
    logic xfer;
    logic shift_busy;
  } usm_tx_t;

  typedef struct packed {
    logic carrier_detect_in_n;
    logic ring_indicator_in_n;
    logic dsr_n;
    logic cts_n;
  } usm_modem_t;
endpackage

// >>> dv/usm_modem_far.sv
// usm_modem_far: far-end modem that moves its control lines after a set lag
`timescale 1ns/1ps
`default_nettype none
module usm_modem_far (
  input  wire logic               sys_clk,
  input  wire logic [3:0]         want_n,
  input  wire logic [3:0]         lag,
  output var usm_pkg::usm_modem_t pins_n
);
  logic [3:0] wait_ff = 4'h0;
  initial pins_n = 4'hf;
  // lines move only after the lag, so a slow modem is seen as well as a prompt one
  always @(posedge sys_clk) begin
    if (pins_n == want_n) begin
      wait_ff <= 4'h0;
    end else if (wait_ff >= lag) begin
      pins_n <= want_n;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> dv/uart_status_and_mode_regs_bench.sv
// uart_status_and_mode_regs_bench: random and corner-case bench of the status and mode block
`timescale 1ns/1ps
`default_nettype none
module uart_status_and_mode_regs_bench;
  logic                  sys_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [7:0]            awaddr = 8'h00;
  logic [7:0]            araddr = 8'h00;
  logic [31:0]           wdata = 32'h0000_0000;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp, rsp;
  logic [31:0]           rdata, rd, sc;
  usm_pkg::usm_rx_char_t rx_char = '0;
  usm_pkg::usm_rx_head_t rx_head = '0;
  usm_pkg::usm_tx_t      tx_stat = '0;
  logic [6:0]            rx_level = 7'h00, tx_level = 7'h00, a, b;
  logic [3:0]            want_n = 4'hf, lag = 4'h0;
  usm_pkg::usm_modem_t   pins_n;
  logic                  rx_fifo_wr, tx_stop, rts_n, dtr_n, sample_16x, line_irq, modem_irq;
  logic [5:0]            hyst_chars;
  int                    fails = 0, checked = 0, cyc = 0, pushes = 0, p0;
  int                    hys [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
  integer                seed = 32'he54d_5978;

  always #2.5 sys_clk = ~sys_clk;

  usm_status_mode dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_char(rx_char), .rx_head(rx_head),
    .tx_stat(tx_stat), .rx_level(rx_level), .tx_level(tx_level), .modem_pins_n(pins_n),
    .rx_fifo_wr(rx_fifo_wr), .tx_stop(tx_stop), .rts_n(rts_n), .dtr_n(dtr_n), .hyst_chars(hyst_chars),
    .sample_16x(sample_16x), .line_irq(line_irq), .modem_irq(modem_irq));

  usm_modem_far far_u (.sys_clk(sys_clk), .want_n(want_n), .lag(lag), .pins_n(pins_n));

  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rx_fifo_wr === 1'b1) pushes <= pushes + 1;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // handshake state is read at the falling edge, so it is settled before the edge that takes it
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge sys_clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      rsp = bresp;
      @(posedge sys_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] ad);
    logic ah, rh;
    @(posedge sys_clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ah = arvalid & arready;
      rh = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge sys_clk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] exp);
    rdr(ad);
    chk("register", exp, rd & m);
  endtask

  task automatic pc(input logic [4:0] c);
    @(posedge sys_clk);
    rx_char <= c;
    @(posedge sys_clk);
    rx_char <= '0;
    tick(3);
  endtask

  task automatic ph(input logic [4:0] c);
    @(posedge sys_clk);
    rx_head <= c;
    @(posedge sys_clk);
    rx_head <= '0;
    tick(3);
  endtask

  function automatic logic [31:0] lvl(input int m, input int k);
    return ((m == 1) || (m == 3 && k == 1)) ? 32'(b) : 32'(a);
  endfunction

  ////////////////////////////////////////////////////////////////
  initial begin
    lag = 4'($random(seed) & 3);
    sc = 32'($random(seed) & 8'hff);
    a = 7'($random(seed)) | 7'h01;
    b = 7'($random(seed));
    tick(20);
    rst_n <= 1'b1;
    rchk(usm_pkg::OFS_SCRATCH, 32'hffff_ffff, 32'h0000_00ff);
    wr(usm_pkg::OFS_SCRATCH, sc);
    rchk(usm_pkg::OFS_SCRATCH, 32'hffff_ffff, sc);
    rdr(8'h40);
    chk("bad read", {30'h0, usm_pkg::RESP_SLVERR}, {30'h0, rsp});
    wr(8'h40, 32'h0000_0001);
    chk("bad write", {30'h0, usm_pkg::RESP_SLVERR}, {30'h0, rsp});
    for (int i = 0; i < 16; i++) begin
      wr(usm_pkg::OFS_CTRL, 32'h0000_0100 | 32'((i & 3) << 6));
      wr(usm_pkg::OFS_SCRATCH, 32'(((i >> 2) << 4) | ((i & 1) << 7)));
      tick(2);
      chk("hysteresis", 32'(hys[i]), 32'(hyst_chars));
      chk("sampling", 32'(i & 1), 32'(sample_16x));
    end
    rx_level <= a;
    tx_level <= b;
    // mode list ends with a second alternating write, which must restart at the receive count
    for (int j = 0; j < 5; j++) begin
      wr(usm_pkg::OFS_SCRATCH, 32'h0000_0080 | 32'(j > 3 ? 3 : j));
      for (int k = 0; k < 3; k++) rchk(usm_pkg::OFS_SCRATCH, 32'hff, lvl(j > 3 ? 3 : j, k));
    end
    wr(usm_pkg::OFS_CTRL, 32'h0000_0800);
    rchk(usm_pkg::OFS_SCRATCH, 32'hff, sc);
    rdr(usm_pkg::OFS_LINE);
    p0 = pushes;
    pc(5'b10001);
    chk("pushes", 32'(p0), 32'(pushes));
    chk("line irq", 32'h1, 32'(line_irq));
    rchk(usm_pkg::OFS_LINE, 32'h1f, 32'h03);
    rchk(usm_pkg::OFS_LINE, 32'h1f, 32'h01);
    for (int f = 0; f < 3; f++) begin
      ph({2'b10, f == 0, f == 1, f == 2});
      rchk(usm_pkg::OFS_LINE, 32'h1f, 32'h01 | (32'h04 << f));
    end
    wr(usm_pkg::OFS_CTRL, 32'h0000_0820);
    p0 = pushes;
    pc(5'b10010);
    pc(5'b10010);
    chk("pushes", 32'(p0 + 1), 32'(pushes));
    chk("line irq", 32'h0, 32'(line_irq));
    rchk(usm_pkg::OFS_LINE, 32'h80, 32'h80);
    ph(5'b01001);
    rchk(usm_pkg::OFS_LINE, 32'h80, 32'h00);
    // immediate line interrupt mode: a parity char raises it on fifo entry
    wr(usm_pkg::OFS_CTRL, 32'h0000_0920);
    wr(usm_pkg::OFS_SCRATCH, 32'h0000_00c0);
    pc(5'b11000);
    chk("line irq", 32'h1, 32'(line_irq));
    wr(usm_pkg::OFS_CTRL, 32'h0000_0800);
    tx_stat <= 3'b100;
    tick(3);
    rchk(usm_pkg::OFS_LINE, 32'h60, 32'h00);
    tx_stat <= 3'b011;
    tick(1);
    tx_stat <= 3'b001;
    tick(2);
    rchk(usm_pkg::OFS_LINE, 32'h60, 32'h20);
    wr(usm_pkg::OFS_CTRL, 32'h0000_0500);
    wr(usm_pkg::OFS_SCRATCH, 32'h0000_0080);
    tick(1);
    chk("direction", 32'h0, 32'(rts_n));
    wr(usm_pkg::OFS_SCRATCH, 32'h0000_0088);
    tick(1);
    chk("direction", 32'h1, 32'(rts_n));
    tx_stat <= 3'b000;
    tick(3);
    chk("direction", 32'h0, 32'(rts_n));
    rchk(usm_pkg::OFS_LINE, 32'h60, 32'h60);
    wr(usm_pkg::OFS_CTRL, 32'h0000_1200);
    rdr(usm_pkg::OFS_MODEM);
    want_n <= 4'he;
    tick(12);
    chk("modem irq", 32'h1, 32'(modem_irq));
    chk("cts hold", 32'h0, 32'(tx_stop));
    rchk(usm_pkg::OFS_MODEM, 32'hff, 32'h11);
    tick(2);
    chk("modem irq", 32'h0, 32'(modem_irq));
    want_n <= 4'hf;
    tick(12);
    chk("cts hold", 32'h1, 32'(tx_stop));
    rchk(usm_pkg::OFS_MODEM, 32'hff, 32'h01);
    want_n <= 4'hb;
    tick(12);
    rchk(usm_pkg::OFS_MODEM, 32'hff, 32'h40);
    want_n <= 4'hf;
    tick(12);
    rchk(usm_pkg::OFS_MODEM, 32'hff, 32'h04);
    want_n <= 4'h5;
    tick(12);
    rchk(usm_pkg::OFS_MODEM, 32'hff, 32'haa);
    wr(usm_pkg::OFS_CTRL, 32'h0000_0016);
    rdr(usm_pkg::OFS_MODEM);
    rchk(usm_pkg::OFS_MODEM, 32'hf0, 32'h50);
    wr(usm_pkg::OFS_CTRL, 32'h0000_0019);
    rchk(usm_pkg::OFS_MODEM, 32'hf0, 32'ha0);
    chk("dtr", 32'h0, 32'(dtr_n));
    test_done;
  end
endmodule
`default_nettype wire
